//--- core/mcch_cfg.svh
/*
  constants for the media card command handler: register offsets,
  command codes, block ranges, field positions and reset values.
  assumes inclusion by bare name from the package and the core module.
*/
`ifndef MCCH_CFG_SVH
`define MCCH_CFG_SVH
// register byte offsets on the wishbone slave
`define MCCH_OFF_CMD 8'h00
`define MCCH_OFF_MODE 8'h04
`define MCCH_OFF_STATUS 8'h08
`define MCCH_OFF_CTRL 8'h0C
`define MCCH_OFF_TRIP 8'h10
`define MCCH_OFF_PARAM 8'h14
// command codes, decimal values written as hex literals
`define MCCH_CODE_BOOT 14'h07D1
`define MCCH_CODE_WS_CLR 14'h2553
`define MCCH_CODE_WS_SET 14'h25C2
`define MCCH_CODE_WP_CLR 14'h2631
`define MCCH_CODE_WP_SET 14'h26A0
`define MCCH_CODE_FORMAT 14'h270F
`define MCCH_CODE_SAVE1 14'h0FA1
// thousands digit selectors
`define MCCH_DIG_SAVE 4'h4
`define MCCH_DIG_PROG 4'h5
`define MCCH_DIG_LOAD 4'h6
`define MCCH_DIG_ERASE 4'h7
`define MCCH_DIG_CMP 4'h8
// block number limits
`define MCCH_BLK_MIN 10'h001
`define MCCH_BLK_MAX 10'h3E7
`define MCCH_BLK_DATA_MAX 10'h1F3
`define MCCH_BLK_BOOT 10'h001
// card mode values
`define MCCH_MODE_IDLE 3'h0
`define MCCH_MODE_PROG 3'h2
// status bit positions
`define MCCH_ST_BUSY 0
`define MCCH_ST_WP 1
`define MCCH_ST_WS 2
`define MCCH_ST_PRESENT 3
// trip bit positions
`define MCCH_TR_CMP 0
`define MCCH_TR_WP 1
`define MCCH_TR_REMOVED 2
`define MCCH_TR_OPTION 3
`define MCCH_TR_RATING 4
`define MCCH_TR_UNSUP 5
`endif

//--- core/mcch_pkg.sv
/*
  types for the media card command handler.
  assumes mcch_cfg.svh sits beside it on the include path.
*/
`include "mcch_cfg.svh"
package mcch_pkg;
  // operation that the card engine carries out
  typedef enum logic [3:0] {
    MCCH_OP_NONE = 4'h0,
    MCCH_OP_SAVE = 4'h1,
    MCCH_OP_PROG = 4'h2,
    MCCH_OP_LOAD = 4'h3,
    MCCH_OP_ERASE = 4'h4,
    MCCH_OP_FORMAT = 4'h5,
    MCCH_OP_CMP = 4'h6
  } mcch_op_e;
  // request handed to the card engine
  typedef struct packed {
    mcch_op_e op;
    logic [9:0] blk;
    logic boot;
    logic diff_only;
    logic overwrite;
    logic skip_rated;
  } mcch_req_s;
  // per-parameter filter inputs from the parameter store
  typedef struct packed {
    logic not_copied;
    logic is_grp20;
    logic is_grp20_first;
    logic differs;
    logic exists;
    logic rated;
  } mcch_pattr_s;
endpackage

//--- core/mcch_core.sv
/*
  media card command handler: decodes the command entry parameter on a
  drive reset, starts card operations, keeps protection flags, raises trips.
  assumes a card engine outside that takes one request and reports done,
  mismatch and option/rating mismatch; software on classic wishbone.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mcch_cfg.svh"
// What this block does
// - act only on code plus drive reset
// - 2001 saves to block 001, bootable
// - 4yyy saves drive parameters to block
// - 5yyy saves user program to block
// - 6yyy loads block into the drive
// - 7yyy erases block; 9999 formats chip card
// - 8yyy compares; match clears, mismatch trips
// - 9555 clears, 9666 sets warning suppression
// - 9777 clears, 9888 sets write protect
// - block number accepted from 001 to 999
// - data blocks numbered 001 through 499
// - write protect allows only loads and 9777
// - card touched only during commanded transfers
// - card removal mid-transfer raises trip
// - saves hold only differences from defaults
// - not-copied excluded; group twenty rest saved
// - card mode 2 saves like 4001
// - mode save keeps trips, overwrites silently
// - card mode returns to 0 after save
// - legacy cards: only difference blocks translated
// - legacy: skip missing, clamp out-of-range
// - write or erase while protected trips
// - suppression hides option/rating trips, skips them
module mcch_core #(
  parameter int CODE_W = 14
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // classic wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // drive side
  input wire logic i_drive_reset,
  input wire logic i_card_present,
  input wire logic i_card_is_sd,
  input wire logic i_card_legacy,
  input wire logic i_blk_is_diff,
  input wire logic i_pattr_valid,
  input wire mcch_pkg::mcch_pattr_s i_pattr,
  input wire logic i_out_of_range,
  // card engine
  output mcch_pkg::mcch_req_s o_req,
  output logic o_req_valid,
  output logic o_card_access,
  input wire logic i_eng_done,
  input wire logic i_eng_mismatch,
  input wire logic i_eng_opt_mis,
  input wire logic i_eng_rate_mis,
  output logic o_param_keep,
  output logic o_param_clamp,
  output logic o_trip
);

  // state of the command sequencer
  typedef enum logic [1:0] {
    MCCH_ST_IDLE = 2'b00,
    MCCH_ST_RUN = 2'b01,
    MCCH_ST_END = 2'b10
  } mcch_state_e;

  mcch_state_e state_reg;
  logic [CODE_W-1:0] cmd_reg; // command entry parameter
  logic [2:0] mode_reg; // card mode setting
  logic wp_reg; // write-protect flag
  logic ws_reg; // warning-suppression flag
  logic [5:0] trip_reg; // sticky trips
  logic mode_save_reg; // current op came from card mode
  mcch_pkg::mcch_req_s req_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // decoded view of the command
  logic [3:0] dig_thou;
  logic [9:0] blk_num;
  logic blk_ok;
  logic is_writey;
  logic allowed;
  mcch_pkg::mcch_req_s dec_req;
  logic dec_is_flag;
  logic start_cmd;
  logic start_mode;
  logic wb_hit;
  logic [5:0] trip_set;
  // split a decimal code into thousands digit and block number
  function automatic logic [3:0] thou_of(input logic [CODE_W-1:0] c);
    logic [3:0] d;
    d = 4'h0;
    for (int k = 1; k <= 9; k++) begin
      if (c >= CODE_W'(k * 1000)) begin
        d = 4'(k);
      end
    end
    return d;
  endfunction

  function automatic logic [9:0] rest_of(input logic [CODE_W-1:0] c,
                                         input logic [3:0] d);
    logic [CODE_W-1:0] r;
    r = c - CODE_W'(d * 1000);
    return r[9:0];
  endfunction

  // write-type op: anything that alters card contents
  function automatic logic alters_card(input mcch_pkg::mcch_op_e op);
    return (op == mcch_pkg::MCCH_OP_SAVE) || (op == mcch_pkg::MCCH_OP_PROG)
      || (op == mcch_pkg::MCCH_OP_ERASE) || (op == mcch_pkg::MCCH_OP_FORMAT);
  endfunction

  assign dig_thou = thou_of(cmd_reg);
  assign blk_num = rest_of(cmd_reg, dig_thou);
  // block field range check
  assign blk_ok = (blk_num >= `MCCH_BLK_MIN) && (blk_num <= `MCCH_BLK_MAX);

  // command decode into an engine request
  always_comb begin
    dec_req = '0;
    dec_is_flag = 1'b0;
    dec_req.blk = blk_num;
    dec_req.diff_only = 1'b1;
    dec_req.skip_rated = ws_reg;
    if (cmd_reg == `MCCH_CODE_BOOT) begin
      dec_req.op = mcch_pkg::MCCH_OP_SAVE;
      dec_req.blk = `MCCH_BLK_BOOT;
      dec_req.boot = 1'b1;
      dec_req.overwrite = 1'b1;
    end else if (cmd_reg == `MCCH_CODE_FORMAT) begin
      // sd media has no format; treated as unsupported below
      dec_req.op = mcch_pkg::MCCH_OP_FORMAT;
    end else if (cmd_reg == `MCCH_CODE_WS_CLR || cmd_reg == `MCCH_CODE_WS_SET ||
                 cmd_reg == `MCCH_CODE_WP_CLR || cmd_reg == `MCCH_CODE_WP_SET) begin
      dec_is_flag = 1'b1;
    end else if (blk_ok) begin
      unique case (dig_thou)
        `MCCH_DIG_SAVE: dec_req.op = mcch_pkg::MCCH_OP_SAVE;
        `MCCH_DIG_PROG: dec_req.op = mcch_pkg::MCCH_OP_PROG;
        `MCCH_DIG_LOAD: dec_req.op = mcch_pkg::MCCH_OP_LOAD;
        `MCCH_DIG_ERASE: dec_req.op = mcch_pkg::MCCH_OP_ERASE;
        `MCCH_DIG_CMP: dec_req.op = mcch_pkg::MCCH_OP_CMP;
        default: dec_req.op = mcch_pkg::MCCH_OP_NONE;
      endcase
    end
    // legacy card: only difference blocks load; saved data stays below block 500
    if (i_card_legacy && dec_req.op == mcch_pkg::MCCH_OP_LOAD && !i_blk_is_diff) begin
      dec_req.op = mcch_pkg::MCCH_OP_NONE;
    end else if (dec_req.blk > `MCCH_BLK_DATA_MAX &&
                 dig_thou inside {`MCCH_DIG_SAVE, `MCCH_DIG_PROG}) begin
      dec_req.op = mcch_pkg::MCCH_OP_NONE;
    end
  end

  // write protect lets only loads and the protect clear through
  assign is_writey = alters_card(dec_req.op);
  assign allowed = !wp_reg || dec_req.op == mcch_pkg::MCCH_OP_LOAD ||
                   cmd_reg == `MCCH_CODE_WP_CLR;
  assign start_cmd = (state_reg == MCCH_ST_IDLE) && i_drive_reset &&
                     cmd_reg != '0;
  assign start_mode = (state_reg == MCCH_ST_IDLE) && i_drive_reset &&
                      cmd_reg == '0 && mode_reg == `MCCH_MODE_PROG;

  // trips raised this cycle
  always_comb begin
    trip_set = '0;
    if (start_cmd && wp_reg && is_writey) begin
      trip_set[`MCCH_TR_WP] = 1'b1;
    end
    if (start_mode && wp_reg) begin
      trip_set[`MCCH_TR_WP] = 1'b1;
    end
    if (start_cmd && allowed && dec_req.op == mcch_pkg::MCCH_OP_FORMAT && i_card_is_sd) begin
      trip_set[`MCCH_TR_UNSUP] = 1'b1;
    end
    if (state_reg == MCCH_ST_RUN && !i_card_present) begin
      trip_set[`MCCH_TR_REMOVED] = 1'b1;
    end
    if (state_reg == MCCH_ST_RUN && i_eng_done) begin
      if (req_reg.op == mcch_pkg::MCCH_OP_CMP && i_eng_mismatch) begin
        trip_set[`MCCH_TR_CMP] = 1'b1;
      end
      // suppression hides option and rating trips
      if (!ws_reg) begin
        trip_set[`MCCH_TR_OPTION] = i_eng_opt_mis;
        trip_set[`MCCH_TR_RATING] = i_eng_rate_mis;
      end
    end
  end

  // sequencer and request register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= MCCH_ST_IDLE;
      req_reg <= '0;
      mode_save_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MCCH_ST_IDLE: begin
          if (start_cmd && allowed && dec_req.op != mcch_pkg::MCCH_OP_NONE &&
              !(dec_req.op == mcch_pkg::MCCH_OP_FORMAT && i_card_is_sd) &&
              i_card_present) begin
            req_reg <= dec_req;
            mode_save_reg <= 1'b0;
            state_reg <= MCCH_ST_RUN;
          end else if (start_mode && !wp_reg && i_card_present) begin
            req_reg <= '0;
            req_reg.op <= mcch_pkg::MCCH_OP_SAVE;
            req_reg.blk <= `MCCH_BLK_BOOT;
            req_reg.diff_only <= 1'b1;
            req_reg.overwrite <= 1'b1;
            req_reg.skip_rated <= ws_reg;
            mode_save_reg <= 1'b1;
            state_reg <= MCCH_ST_RUN;
          end
        end
        MCCH_ST_RUN: begin
          // removal aborts; engine done ends normally
          if (!i_card_present || i_eng_done) begin
            state_reg <= MCCH_ST_END;
          end
        end
        MCCH_ST_END: begin
          state_reg <= MCCH_ST_IDLE;
        end
        default: state_reg <= MCCH_ST_IDLE;
      endcase
    end
  end

  // card is driven only while a transfer runs
  assign o_card_access = (state_reg == MCCH_ST_RUN);
  assign o_req_valid = (state_reg == MCCH_ST_RUN);
  assign o_req = req_reg;

  // per-parameter filter: which entries go onto or come off the card
  always_comb begin
    o_param_keep = 1'b0;
    o_param_clamp = 1'b0;
    if (state_reg == MCCH_ST_RUN && i_pattr_valid) begin
      if (req_reg.op == mcch_pkg::MCCH_OP_SAVE) begin
        // group twenty rides along, minus its first entry
        o_param_keep = !i_pattr.not_copied && !i_pattr.is_grp20_first &&
                       (i_pattr.differs || i_pattr.is_grp20);
      end else if (req_reg.op == mcch_pkg::MCCH_OP_LOAD) begin
        // missing parameters from legacy cards are skipped
        o_param_keep = i_pattr.exists && !(req_reg.skip_rated && i_pattr.rated);
        o_param_clamp = i_card_legacy && i_pattr.exists && i_out_of_range;
      end
    end
  end

  // write protect and warning suppression flags
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wp_reg <= 1'b0;
      ws_reg <= 1'b0;
    end else if (start_cmd && allowed && dec_is_flag) begin
      if (cmd_reg == `MCCH_CODE_WS_CLR) ws_reg <= 1'b0;
      if (cmd_reg == `MCCH_CODE_WS_SET) ws_reg <= 1'b1;
      if (cmd_reg == `MCCH_CODE_WP_CLR) wp_reg <= 1'b0;
      if (cmd_reg == `MCCH_CODE_WP_SET) wp_reg <= 1'b1;
    end
  end

  // sticky trips, set beats a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      trip_reg <= '0;
    end else if (wb_hit && i_wb_we && i_wb_adr == `MCCH_OFF_TRIP && i_wb_sel[0]) begin
      trip_reg <= (trip_reg & ~i_wb_dat[5:0]) | trip_set;
    end else begin
      trip_reg <= trip_reg | trip_set;
    end
  end
  assign o_trip = |trip_reg;
  assign wb_hit = i_wb_cyc && i_wb_stb && !ack_reg;

  // command entry parameter: software write, auto return on good compare
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmd_reg <= '0;
    end else if (state_reg == MCCH_ST_END && !mode_save_reg &&
                 req_reg.op == mcch_pkg::MCCH_OP_CMP && !trip_reg[`MCCH_TR_CMP] &&
                 i_card_present) begin
      cmd_reg <= '0;
    end else if (wb_hit && i_wb_we && i_wb_adr == `MCCH_OFF_CMD) begin
      if (i_wb_sel[0]) cmd_reg[7:0] <= i_wb_dat[7:0];
      if (i_wb_sel[1]) cmd_reg[CODE_W-1:8] <= i_wb_dat[CODE_W-1:8];
    end
  end

  // card mode setting, cleared after its save ends
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_reg <= `MCCH_MODE_IDLE;
    end else if (state_reg == MCCH_ST_END && mode_save_reg && i_card_present) begin
      mode_reg <= `MCCH_MODE_IDLE;
    end else if (wb_hit && i_wb_we && i_wb_adr == `MCCH_OFF_MODE && i_wb_sel[0]) begin
      mode_reg <= i_wb_dat[2:0];
    end
  end

  // wishbone read data and ack, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_hit;
      rdat_reg <= 32'h0000_0000;
      if (wb_hit && !i_wb_we) begin
        unique case (i_wb_adr)
          `MCCH_OFF_CMD: rdat_reg <= {{(32-CODE_W){1'b0}}, cmd_reg};
          `MCCH_OFF_MODE: rdat_reg <= {29'h0000_0000, mode_reg};
          `MCCH_OFF_STATUS: rdat_reg <= {28'h000_0000, i_card_present, ws_reg,
                                         wp_reg, state_reg != MCCH_ST_IDLE};
          `MCCH_OFF_TRIP: rdat_reg <= {26'h000_0000, trip_reg};
          default: rdat_reg <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  // assertions
  property p_access_only_run;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_card_access |-> o_req.op != mcch_pkg::MCCH_OP_NONE;
  endproperty
  a_access_only_run: assert property (p_access_only_run) else $error("card access with no operation");

  property p_no_start_without_reset;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_req_valid) |-> $past(i_drive_reset);
  endproperty
  a_no_start_without_reset: assert property (p_no_start_without_reset) else $error("start without reset");

  property p_removal_trip;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == MCCH_ST_RUN && !i_card_present) |=> trip_reg[`MCCH_TR_REMOVED];
  endproperty
  a_removal_trip: assert property (p_removal_trip) else $error("no removal trip");

  sequence s_cmp_done;
    state_reg == MCCH_ST_RUN && req_reg.op == mcch_pkg::MCCH_OP_CMP && i_eng_done;
  endsequence
  property p_cmp_mismatch;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_cmp_done ##0 i_eng_mismatch |=> trip_reg[`MCCH_TR_CMP];
  endproperty
  a_cmp_mismatch: assert property (p_cmp_mismatch) else $error("no compare trip");

  property p_wp_write_trip;
    @(posedge i_clk) disable iff (i_sys_rst)
      (start_cmd && wp_reg && is_writey) |=> trip_reg[`MCCH_TR_WP] && !o_req_valid;
  endproperty
  a_wp_write_trip: assert property (p_wp_write_trip) else $error("protected write not stopped");

  property p_wp_blocks;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_req_valid) && $past(wp_reg) |-> o_req.op == mcch_pkg::MCCH_OP_LOAD;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) else $error("op ran while protected");

  property p_mode_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == MCCH_ST_END && mode_save_reg && i_card_present) |=> mode_reg == 3'h0;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("card mode not cleared");

  property p_ws_set;
    @(posedge i_clk) disable iff (i_sys_rst)
      (start_cmd && !wp_reg && cmd_reg == `MCCH_CODE_WS_SET) |=> ws_reg ##1 !o_req_valid;
  endproperty
  a_ws_set: assert property (p_ws_set) else $error("suppression not set");

  property p_ws_hides;
    @(posedge i_clk) disable iff (i_sys_rst)
      ws_reg && !$past(trip_reg[`MCCH_TR_OPTION]) && !$past(i_sys_rst)
        |-> !trip_reg[`MCCH_TR_OPTION] || !$past(ws_reg);
  endproperty
  a_ws_hides: assert property (p_ws_hides) else $error("option trip while suppressed");

endmodule
`default_nettype wire

//--- tb/mcch_card_model.sv
/*
  card engine stand-in: answers each request with a done pulse after a set
  number of cycles, or never when the latency is 8'hFF.
  assumes one clock shared with the handler and a synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mcch_card_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire logic [7:0] i_lat,
  input wire logic i_mis,
  input wire logic i_opt,
  input wire logic i_rate,
  output logic o_done,
  output logic o_mismatch,
  output logic o_opt_mis,
  output logic o_rate_mis
);
  logic [7:0] cnt_reg; // cycles spent on the current request
  logic tog_reg; // filler for result lines between answers
  // the card only works while a request stands
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_req_valid) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // one done pulse; latency 8'hFF stalls so a removal can cut in
  always_ff @(posedge i_clk) begin
    o_done <= !i_sys_rst && i_req_valid && cnt_reg == i_lat && i_lat != 8'hFF;
  end
  // free-running toggle, never a held last value
  always_ff @(posedge i_clk) begin
    tog_reg <= i_sys_rst ? 1'b0 : !tog_reg;
  end
  // results only mean something beside done
  assign o_mismatch = o_done ? i_mis : tog_reg;
  assign o_opt_mis = o_done ? i_opt : !tog_reg;
  assign o_rate_mis = o_done ? i_rate : tog_reg;
endmodule
`default_nettype wire

//--- tb/media_card_command_handler_tb_top.sv
/*
  bench top for the media card command handler: wishbone master tasks,
  expectation queues and a watcher that compares results as they appear.
  assumes mcch_core and mcch_card_model are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mcch_cfg.svh"
module media_card_command_handler_tb_top;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0000_0000;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic drv_rst = 1'b0; // drive reset pulse
  logic present = 1'b1; // card inserted
  logic is_sd = 1'b0;
  logic pv = 1'b0;
  mcch_pkg::mcch_pattr_s pattr = 6'h00;
  mcch_pkg::mcch_req_s o_req;
  logic o_req_valid, o_card_access, done, mis_o, opt_o, rate_o, keep, clamp, trip;
  logic [7:0] lat = 8'h02; // engine answer delay
  logic mis = 1'b0;
  logic opt = 1'b0;
  logic rate = 1'b0;
  logic leg = 1'b0, dif = 1'b0, oor = 1'b0; // legacy card, difference block, out of range
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'h0000_000D;
  logic [31:0] exp_rd[$]; // expected read data
  logic [15:0] exp_req[$]; // {blk cared, op, blk, boot}
  logic [15:0] e_req;
  logic rv_q = 1'b0;
  logic [9:0] rb;

  always #5 i_clk = ~i_clk;

  mcch_core mcch_core_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_drive_reset(drv_rst),
    .i_card_present(present), .i_card_is_sd(is_sd), .i_card_legacy(leg),
    .i_blk_is_diff(dif), .i_pattr_valid(pv), .i_pattr(pattr), .i_out_of_range(oor),
    .o_req(o_req), .o_req_valid(o_req_valid), .o_card_access(o_card_access),
    .i_eng_done(done), .i_eng_mismatch(mis_o), .i_eng_opt_mis(opt_o),
    .i_eng_rate_mis(rate_o), .o_param_keep(keep), .o_param_clamp(clamp), .o_trip(trip));

  mcch_card_model mcch_card_model_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_req_valid(o_req_valid), .i_lat(lat), .i_mis(mis), .i_opt(opt), .i_rate(rate),
    .o_done(done), .o_mismatch(mis_o), .o_opt_mis(opt_o), .o_rate_mis(rate_o));

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // watcher: oldest note is taken off whenever a result shows
  always @(posedge i_clk) begin
    rv_q <= o_req_valid;
    if (!i_sys_rst) chk("card_access", {31'h0, o_req_valid}, {31'h0, o_card_access});
    if (o_wb_ack === 1'b1 && !i_wb_we) begin
      if (exp_rd.size() == 0) chk("read extra", 32'h0, 32'h1);
      else chk("read data", exp_rd.pop_front(), o_wb_dat);
    end
    if (o_req_valid === 1'b1 && rv_q !== 1'b1) begin
      if (exp_req.size() == 0) chk("request extra", 32'h0, 32'h1);
      else begin
        e_req = exp_req.pop_front();
        chk("request", {16'h0, e_req}, {16'h0, e_req[15], o_req.op,
          e_req[15] ? o_req.blk : e_req[10:1], o_req.boot});
      end
    end
  end

  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 64);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    @(posedge i_clk);
    if (n >= 64) begin
      chk("ack wait", 32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, adr, 32'h0000_0000);
  endtask

  task automatic pulse();
    drv_rst <= 1'b1;
    @(posedge i_clk);
    drv_rst <= 1'b0;
  endtask

  function automatic logic [13:0] cd(input logic [3:0] d, input logic [9:0] b);
    return 14'(d) * 14'h03E8 + 14'(b);
  endfunction

  // enter a code, reset the drive, wait out any transfer
  task automatic run_cmd(input logic [13:0] code, input logic [15:0] e);
    int n;
    n = 0;
    wb(1'b1, `MCCH_OFF_CMD, {18'h0, code});
    if (e[14:11] != 4'h0) exp_req.push_back(e);
    pulse();
    repeat (2) @(posedge i_clk);
    while (o_req_valid === 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    chk("request missing", 32'h0, exp_req.size());
    if (n >= 400) begin
      chk("transfer wait", 32'h0, 32'h1);
      final_report();
    end
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(`MCCH_OFF_CMD, 32'h0000_0000);
    rd(`MCCH_OFF_STATUS, 32'h0000_0008);
    rd(`MCCH_OFF_TRIP, 32'h0000_0000);
    wb(1'b1, `MCCH_OFF_PARAM, 32'hFFFF_FFFF);
    rd(`MCCH_OFF_PARAM, 32'h0000_0000);
    rd(`MCCH_OFF_CTRL, 32'h0000_0000);
    wb(1'b1, `MCCH_OFF_CMD, {18'h0, cd(`MCCH_DIG_SAVE, 10'h005)});
    repeat (4) @(posedge i_clk);
    $display("test reset done");
    rb = 10'h001 + 10'((32'($random(seed)) & 32'h0000_7FFF) % 32'h0000_01F3);
    run_cmd(`MCCH_CODE_BOOT, {1'b1, mcch_pkg::MCCH_OP_SAVE, `MCCH_BLK_BOOT, 1'b1});
    run_cmd(cd(`MCCH_DIG_SAVE, rb), {1'b1, mcch_pkg::MCCH_OP_SAVE, rb, 1'b0});
    run_cmd(cd(`MCCH_DIG_PROG, 10'h001), {1'b1, mcch_pkg::MCCH_OP_PROG, 10'h001, 1'b0});
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h1F3), {1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h1F3, 1'b0});
    run_cmd(cd(`MCCH_DIG_ERASE, 10'h3E7), {1'b1, mcch_pkg::MCCH_OP_ERASE, 10'h3E7, 1'b0});
    run_cmd(`MCCH_CODE_FORMAT, {1'b0, mcch_pkg::MCCH_OP_FORMAT, 10'h000, 1'b0});
    run_cmd(cd(`MCCH_DIG_CMP, 10'h005), {1'b1, mcch_pkg::MCCH_OP_CMP, 10'h005, 1'b0});
    rd(`MCCH_OFF_CMD, 32'h0000_0000);
    mis <= 1'b1;
    run_cmd(cd(`MCCH_DIG_CMP, 10'h006), {1'b1, mcch_pkg::MCCH_OP_CMP, 10'h006, 1'b0});
    rd(`MCCH_OFF_TRIP, 32'h0000_0001);
    rd(`MCCH_OFF_CMD, {18'h0, cd(`MCCH_DIG_CMP, 10'h006)});
    mis <= 1'b0;
    wb(1'b1, `MCCH_OFF_TRIP, 32'h0000_003F);
    run_cmd(14'h04D2, 16'h0000);
    run_cmd(cd(`MCCH_DIG_SAVE, 10'h000), 16'h0000);
    run_cmd(cd(`MCCH_DIG_SAVE, 10'h1F4), 16'h0000);
    rd(`MCCH_OFF_TRIP, 32'h0000_0000);
    $display("test codes done");
    run_cmd(`MCCH_CODE_WP_SET, 16'h0000);
    rd(`MCCH_OFF_STATUS, 32'h0000_000A);
    run_cmd(cd(`MCCH_DIG_SAVE, 10'h00A), 16'h0000);
    rd(`MCCH_OFF_TRIP, 32'h0000_0002);
    run_cmd(cd(`MCCH_DIG_ERASE, 10'h00A), 16'h0000);
    run_cmd(`MCCH_CODE_WS_SET, 16'h0000);
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h00A), {1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h00A, 1'b0});
    run_cmd(`MCCH_CODE_WP_CLR, 16'h0000);
    rd(`MCCH_OFF_STATUS, 32'h0000_0008);
    wb(1'b1, `MCCH_OFF_TRIP, 32'h0000_003F);
    $display("test protect done");
    run_cmd(`MCCH_CODE_WS_SET, 16'h0000);
    rd(`MCCH_OFF_STATUS, 32'h0000_000C);
    opt <= 1'b1;
    rate <= 1'b1;
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h001), {1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h001, 1'b0});
    rd(`MCCH_OFF_TRIP, 32'h0000_0000);
    run_cmd(`MCCH_CODE_WS_CLR, 16'h0000);
    rd(`MCCH_OFF_STATUS, 32'h0000_0008);
    rate <= 1'b0;
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h001), {1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h001, 1'b0});
    rd(`MCCH_OFF_TRIP, 32'h0000_0008);
    wb(1'b1, `MCCH_OFF_TRIP, 32'h0000_003F);
    opt <= 1'b0;
    rate <= 1'b1;
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h001), {1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h001, 1'b0});
    rd(`MCCH_OFF_TRIP, 32'h0000_0010);
    rate <= 1'b0;
    wb(1'b1, `MCCH_OFF_TRIP, 32'h0000_003F);
    is_sd <= 1'b1;
    run_cmd(`MCCH_CODE_FORMAT, 16'h0000);
    rd(`MCCH_OFF_TRIP, 32'h0000_0020);
    is_sd <= 1'b0;
    wb(1'b1, `MCCH_OFF_TRIP, 32'h0000_003F);
    wb(1'b1, `MCCH_OFF_MODE, 32'h0000_0002);
    run_cmd(14'h0000, {1'b1, mcch_pkg::MCCH_OP_SAVE, 10'h001, 1'b0});
    rd(`MCCH_OFF_MODE, 32'h0000_0000);
    $display("test flags done");
    // stalled save: filter lines, then the card is pulled out mid-transfer
    lat <= 8'hFF;
    exp_req.push_back({1'b1, mcch_pkg::MCCH_OP_SAVE, 10'h014, 1'b0});
    wb(1'b1, `MCCH_OFF_CMD, {18'h0, cd(`MCCH_DIG_SAVE, 10'h014)});
    pulse();
    repeat (3) @(posedge i_clk);
    pattr <= 6'h27;
    pv <= 1'b1;
    @(posedge i_clk);
    chk("param_keep", 32'h0, {31'h0, keep});
    pattr <= 6'h02;
    @(posedge i_clk);
    chk("param_keep", 32'h0, {31'h0, keep});
    pattr <= 6'h10;
    @(posedge i_clk);
    chk("param_keep", 32'h1, {31'h0, keep});
    present <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("req_valid", 32'h0, {31'h0, o_req_valid});
    rd(`MCCH_OFF_TRIP, 32'h0000_0004);
    chk("trip", 32'h1, {31'h0, trip});
    present <= 1'b1;
    $display("test removal done");
    // legacy card: plain block refused, difference block loads with filtering
    leg <= 1'b1;
    run_cmd(cd(`MCCH_DIG_LOAD, 10'h003), 16'h0000);
    dif <= 1'b1;
    exp_req.push_back({1'b1, mcch_pkg::MCCH_OP_LOAD, 10'h003, 1'b0});
    wb(1'b1, `MCCH_OFF_CMD, {18'h0, cd(`MCCH_DIG_LOAD, 10'h003)});
    pulse();
    repeat (3) @(posedge i_clk);
    pattr <= 6'h00;
    oor <= 1'b1;
    @(posedge i_clk);
    chk("param_keep", 32'h0, {31'h0, keep});
    chk("param_clamp", 32'h0, {31'h0, clamp});
    pattr <= 6'h02;
    @(posedge i_clk);
    chk("param_keep", 32'h1, {31'h0, keep});
    chk("param_clamp", 32'h1, {31'h0, clamp});
    present <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("request missing", 32'h0, exp_req.size());
    $display("test legacy done");
    final_report();
  end
endmodule
`default_nettype wire
